// ==== design/hlt_pkg.sv ====
// Shared constants for the limit-timer mode control block
package hlt_pkg;

    // Mode field layout
    localparam int unsigned MODE_W     = 5;   // Whole mode field width
    localparam int unsigned FAM_MSB    = 4;   // Family bits [4:3]
    localparam int unsigned FAM_LSB    = 3;
    localparam int unsigned VAR_MSB    = 2;   // Variant bits [2:0]
    localparam int unsigned VAR_LSB    = 0;

    // Mode families
    localparam logic [1:0] FAM_FREE    = 2'h0;   // Free-running period
    localparam logic [1:0] FAM_ONESHOT = 2'h1;   // One-shot
    localparam logic [1:0] FAM_MONO    = 2'h2;   // Monostable and level one-shot

    // Variant codes
    localparam logic [2:0] VAR_0       = 3'h0;
    localparam logic [2:0] VAR_1       = 3'h1;
    localparam logic [2:0] VAR_2       = 3'h2;
    localparam logic [2:0] VAR_3       = 3'h3;
    localparam logic [2:0] VAR_4       = 3'h4;
    localparam logic [2:0] VAR_5       = 3'h5;
    localparam logic [2:0] VAR_6       = 3'h6;
    localparam logic [2:0] VAR_7       = 3'h7;

    // Edge selectors for start or reset triggers
    localparam logic [1:0] EDGE_NONE   = 2'h0;
    localparam logic [1:0] EDGE_RISE   = 2'h1;
    localparam logic [1:0] EDGE_FALL   = 2'h2;
    localparam logic [1:0] EDGE_ANY    = 2'h3;

    // Reset values
    localparam logic [7:0] CNT_RST_VAL = 8'h00;  // Count after reset, hardware clear or period match
    localparam logic       ON_RST_VAL  = 1'b0;   // Enable bit after reset

    // Far-side timing demands, in timer clock periods
    localparam int unsigned EDGE_SPACING_CYC = 6;  // Between trigger edges
    localparam int unsigned LEVEL_HOLD_CYC   = 3;  // Least trigger level time

    // Synchroniser depth on the external reset signal
    localparam int unsigned SYNC_STAGES = 3;

    // Pick an edge out of rise/fall by selector
    function automatic logic edge_pick(input logic [1:0] sel,
                                       input logic       rise,
                                       input logic       fall);
        logic hit;
        hit = 1'b0;
        case (sel)
            EDGE_RISE: hit = rise;
            EDGE_FALL: hit = fall;
            EDGE_ANY:  hit = rise | fall;
            default:   hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Edge selector for variants 1..3 (rise, fall, any)
    function automatic logic [1:0] start_edge_sel(input logic [2:0] v);
        logic [1:0] sel;
        sel = EDGE_NONE;
        case (v)
            VAR_1:   sel = EDGE_RISE;
            VAR_2:   sel = EDGE_FALL;
            VAR_3:   sel = EDGE_ANY;
            default: sel = EDGE_NONE;
        endcase
        return sel;
    endfunction

endpackage

// ==== design/hlt_sync.sv ====
`timescale 1ns/100ps
// Three-stage input synchroniser with agreement filter and edge detect
module hlt_sync (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic async_in,    // Raw external level
    output logic      level_r,     // Filtered level
    output logic      rise_r,      // One-cycle pulse on filtered rise
    output logic      fall_r       // One-cycle pulse on filtered fall
);

    logic meta_r;   // First stage, read only by the second
    logic s2_r;     // Second stage
    logic s3_r;     // Third stage

    // Capture chain; reset to low so no false edge after release
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_r <= 1'b0;
            s2_r   <= 1'b0;
            s3_r   <= 1'b0;
        end else begin
            meta_r <= async_in;
            s2_r   <= meta_r;
            s3_r   <= s2_r;
        end
    end

    // Accept a change only once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (rst) begin
            level_r <= 1'b0;
            rise_r  <= 1'b0;
            fall_r  <= 1'b0;
        end else begin
            rise_r <= 1'b0;
            fall_r <= 1'b0;
            if (s2_r == s3_r && s3_r != level_r) begin
                level_r <= s3_r;
                rise_r  <= s3_r;
                fall_r  <= ~s3_r;
            end
        end
    end

endmodule

// ==== design/hlt_cnt.sv ====
`timescale 1ns/100ps
// Period counter with load, clear, increment and period match
module hlt_cnt #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             load,        // Software write of the count
    input  wire logic [WIDTH-1:0] load_val,
    input  wire logic             clr,         // Hardware count reset
    input  wire logic             inc,         // Count one timer clock
    input  wire logic [WIDTH-1:0] period,      // Period value
    output logic      [WIDTH-1:0] cnt_r,       // Count value
    output logic                  match        // Count equals period
);

    // Width check; the reset constant is eight bits wide
    initial begin
        if (WIDTH < 1 || WIDTH > 8) begin
            $error("hlt_cnt: WIDTH must be 1 to 8");
        end
    end

    assign match = (cnt_r == period);

    // Load beats hardware clear, clear beats counting
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_r <= hlt_pkg::CNT_RST_VAL[WIDTH-1:0];
        end else if (load) begin
            cnt_r <= load_val;
        end else if (clr) begin
            cnt_r <= hlt_pkg::CNT_RST_VAL[WIDTH-1:0];
        end else if (inc) begin
            // Match folds back to zero on this clock
            cnt_r <= match ? hlt_pkg::CNT_RST_VAL[WIDTH-1:0] : cnt_r + 1'b1;
        end
    end

endmodule

// ==== design/hlt_timer.sv ====
`timescale 1ns/100ps
// Functional notes
// RULE1: Five-bit mode: family upper two, variant lower three
// RULE2: Trigger source spaces edges six clocks apart
// RULE3: Trigger source holds levels three clocks minimum
// RULE4: Debug mode ignores all external triggers; free-mode gating still follows the level
// RULE5: Free 000/001/010: software, high, low gating
// RULE6: Free 011/100/101: any/rise/fall edge clears count
// RULE7: Free 110/111: hold count cleared low/high
// RULE8: One-shot 000: enable starts, match or disable stops
// RULE9: One-shot 001/010/011: rise/fall/any edge starts
// RULE10: One-shot 100/101: edge both starts and resets
// RULE11: One-shot 110/111: edge start, opposite level reset
// RULE12: Monostable 001/010/011: edge starts, match stops
// RULE13: Codes 10110/10111: level start, opposite level reset
// RULE14: One-shot match: next clock clears enable, zero
// RULE15: Monostable match: stop at zero, enable kept
// RULE16: Enable rising waits for qualifying edge
// RULE17: Software avoids reserved mode codes
// RULE18: Synchronise external signal before any detection
module hlt_timer #(
    parameter int unsigned CNT_W = 8        // Count and period width
) (
    input  wire logic                           core_clk,
    input  wire logic                           rst,
    input  wire logic [hlt_pkg::MODE_W-1:0]     mode,         // Mode field
    input  wire logic                           on_wr,        // Enable bit write strobe
    input  wire logic                           on_wdata,     // Enable bit write value
    input  wire logic                           count_wr,     // Count write strobe
    input  wire logic [CNT_W-1:0]               count_wdata,  // Count write value
    input  wire logic [CNT_W-1:0]               period_value, // Period value
    input  wire logic                           debug_mode,   // Core halted in debug
    input  wire logic                           external_reset_signal,
    output logic                                on_r,         // Enable bit readback
    output logic      [CNT_W-1:0]               count_value,  // Count readback
    output logic                                running_r,    // Timer is counting
    output logic                                period_match_r // Pulse after match
);

    // Width check at simulation start
    initial begin
        if (CNT_W < 1 || CNT_W > 8) begin
            $error("hlt_timer: CNT_W must be 1 to 8");
        end
    end

    // Run state of start/stop families
    typedef enum logic {
        HLT_IDLE,
        HLT_RUN
    } hlt_state_t;

    hlt_state_t state_r;           // Current run state
    hlt_state_t state_nxt;         // Next run state

    logic [1:0] fam;               // Mode family
    logic [2:0] vsel;              // Mode variant
    logic       ers_lvl;           // Synchronised external level
    logic       ers_rise;          // Synchronised rising pulse
    logic       ers_fall;          // Synchronised falling pulse
    logic       trig_rise;         // Rising edge, debug-masked
    logic       trig_fall;         // Falling edge, debug-masked
    logic       trig_hi;           // High level, debug-masked
    logic       trig_lo;           // Low level, debug-masked
    logic       cnt_clr;           // Hardware count reset
    logic       cnt_inc;           // Count this clock
    logic       start;             // Start condition met
    logic       lvl_stop;          // Held in reset stops the run
    logic       oneshot_type;      // Match clears the enable bit
    logic       match;             // Count equals period
    logic       stop_match;        // Counting clock with period match
    logic       hw_on_clr;         // Hardware clear of enable bit

    // Mode field split into family and variant
    assign fam  = mode[hlt_pkg::FAM_MSB:hlt_pkg::FAM_LSB];  // [RULE1]
    assign vsel = mode[hlt_pkg::VAR_MSB:hlt_pkg::VAR_LSB];  // [RULE1]

    // External signal conditioning before any decision
    hlt_sync u_sync (                                         // [RULE18]
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (external_reset_signal),
        .level_r  (ers_lvl),
        .rise_r   (ers_rise),
        .fall_r   (ers_fall)
    );

    // Debug masks triggers and resets; plain gating keeps the level
    assign trig_rise = ers_rise & ~debug_mode;   // [RULE4]
    assign trig_fall = ers_fall & ~debug_mode;   // [RULE4]
    assign trig_hi   = ers_lvl & ~debug_mode;    // [RULE4]
    assign trig_lo   = ~ers_lvl & ~debug_mode;   // [RULE4]

    // Mode decode: start, reset and count conditions
    always_comb begin
        cnt_clr      = 1'b0;
        cnt_inc      = 1'b0;
        start        = 1'b0;
        lvl_stop     = 1'b0;
        oneshot_type = 1'b0;
        case (fam)
            hlt_pkg::FAM_FREE: begin
                // Free-running: no run state, enable steers directly
                case (vsel)
                    hlt_pkg::VAR_0: begin
                        cnt_inc = on_r;                          // [RULE5]
                    end
                    hlt_pkg::VAR_1: begin
                        cnt_inc = on_r & ers_lvl;                // [RULE5]
                    end
                    hlt_pkg::VAR_2: begin
                        cnt_inc = on_r & ~ers_lvl;               // [RULE5]
                    end
                    hlt_pkg::VAR_3, hlt_pkg::VAR_4, hlt_pkg::VAR_5: begin
                        // Edge selector: variant 011 any, 100 rise, 101 fall
                        cnt_clr = on_r & hlt_pkg::edge_pick(
                            (vsel == hlt_pkg::VAR_3) ? hlt_pkg::EDGE_ANY :
                            (vsel == hlt_pkg::VAR_4) ? hlt_pkg::EDGE_RISE :
                                                       hlt_pkg::EDGE_FALL,
                            trig_rise, trig_fall);               // [RULE6]
                        cnt_inc = on_r & ~cnt_clr;               // [RULE6]
                    end
                    hlt_pkg::VAR_6: begin
                        cnt_clr = on_r & trig_lo;                // [RULE7]
                        cnt_inc = on_r & ~cnt_clr;               // [RULE7]
                    end
                    default: begin
                        cnt_clr = on_r & trig_hi;                // [RULE7]
                        cnt_inc = on_r & ~cnt_clr;               // [RULE7]
                    end
                endcase
            end
            hlt_pkg::FAM_ONESHOT: begin
                oneshot_type = 1'b1;                             // [RULE14]
                case (vsel)
                    hlt_pkg::VAR_0: begin
                        start = 1'b1;                            // [RULE8]
                    end
                    hlt_pkg::VAR_1, hlt_pkg::VAR_2, hlt_pkg::VAR_3: begin
                        start = hlt_pkg::edge_pick(hlt_pkg::start_edge_sel(vsel),
                                                   trig_rise, trig_fall); // [RULE9]
                    end
                    hlt_pkg::VAR_4: begin
                        start   = trig_rise;                     // [RULE10]
                        cnt_clr = trig_rise & on_r;              // [RULE10]
                    end
                    hlt_pkg::VAR_5: begin
                        start   = trig_fall;                     // [RULE10]
                        cnt_clr = trig_fall & on_r;              // [RULE10]
                    end
                    hlt_pkg::VAR_6: begin
                        start   = trig_rise;                     // [RULE11]
                        cnt_clr = trig_lo & on_r;                // [RULE11]
                    end
                    default: begin
                        start   = trig_fall;                     // [RULE11]
                        cnt_clr = trig_hi & on_r;                // [RULE11]
                    end
                endcase
                cnt_inc = (state_r == HLT_RUN) & on_r & ~cnt_clr;  // [RULE8]
            end
            hlt_pkg::FAM_MONO: begin
                case (vsel)
                    hlt_pkg::VAR_1, hlt_pkg::VAR_2, hlt_pkg::VAR_3: begin
                        start = hlt_pkg::edge_pick(hlt_pkg::start_edge_sel(vsel),
                                                   trig_rise, trig_fall); // [RULE12]
                    end
                    hlt_pkg::VAR_6: begin
                        oneshot_type = 1'b1;                     // [RULE13]
                        start        = trig_hi;                  // [RULE13]
                        cnt_clr      = trig_lo & on_r;           // [RULE13]
                        lvl_stop     = trig_lo;                  // [RULE13]
                    end
                    hlt_pkg::VAR_7: begin
                        oneshot_type = 1'b1;                     // [RULE13]
                        start        = trig_lo;                  // [RULE13]
                        cnt_clr      = trig_hi & on_r;           // [RULE13]
                        lvl_stop     = trig_hi;                  // [RULE13]
                    end
                    default: begin
                        // Reserved variants: timer stays parked
                        start = 1'b0;
                    end
                endcase
                cnt_inc = (state_r == HLT_RUN) & on_r & ~cnt_clr;  // [RULE12]
            end
            default: begin
                // Reserved family: nothing counts
                cnt_inc = 1'b0;
            end
        endcase
    end

    // Match only stops the run on a clock that actually counts
    assign stop_match = cnt_inc & match;
    assign hw_on_clr  = stop_match & oneshot_type;               // [RULE14]

    // Run state; idle whenever disabled, so a fresh enable waits for a start
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            HLT_IDLE: begin
                if (on_r && start && fam != hlt_pkg::FAM_FREE) begin
                    state_nxt = HLT_RUN;                         // [RULE16]
                end
            end
            HLT_RUN: begin
                if (!on_r || stop_match || lvl_stop) begin
                    state_nxt = HLT_IDLE;                        // [RULE15]
                end
            end
            default: begin
                state_nxt = HLT_IDLE;
            end
        endcase
    end

    // Run state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= HLT_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Enable bit; a software write wins over a same-clock hardware clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            on_r <= hlt_pkg::ON_RST_VAL;
        end else if (on_wr) begin
            on_r <= on_wdata;
        end else if (hw_on_clr) begin
            on_r <= 1'b0;                                        // [RULE14]
        end
    end

    // Period counter; match folds the count to zero on the next clock
    hlt_cnt #(
        .WIDTH (CNT_W)
    ) u_cnt (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (count_wr),
        .load_val (count_wdata),
        .clr      (cnt_clr),
        .inc      (cnt_inc),
        .period   (period_value),
        .cnt_r    (count_value),
        .match    (match)
    );

    // Status outputs from flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            running_r      <= 1'b0;
            period_match_r <= 1'b0;
        end else begin
            running_r      <= cnt_inc;
            period_match_r <= stop_match;                        // [RULE15]
        end
    end

endmodule

// ==== sim/hlt_timer_asserts.sv ====
`timescale 1ns/100ps
// Port checks of the limit-timer mode behaviour
module hlt_timer_asserts #(
    parameter int unsigned CNT_W = 8
) (
    input wire logic                       core_clk,
    input wire logic                       rst,
    input wire logic [hlt_pkg::MODE_W-1:0] mode,
    input wire logic                       on_wr,
    input wire logic                       on_wdata,
    input wire logic                       count_wr,
    input wire logic [CNT_W-1:0]           count_wdata,
    input wire logic [CNT_W-1:0]           period_value,
    input wire logic                       debug_mode,
    input wire logic                       external_reset_signal,
    input wire logic                       on_r,
    input wire logic [CNT_W-1:0]           count_value,
    input wire logic                       running_r,
    input wire logic                       period_match_r
);
    logic [CNT_W-1:0] cnt_inc;  // Count one step on, wrapping
    assign cnt_inc = count_value + 1'h1;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Level held five clocks, long enough to pass the synchroniser
    sequence held_s(logic [4:0] m, logic lvl);
        (mode == m && external_reset_signal == lvl && !on_wr && !count_wr && !debug_mode)[*5];
    endsequence
    // Halted core, rising-edge clear mode, timer enabled
    sequence dbg_run_s;
        (debug_mode && mode == 5'h04 && on_r && !on_wr && !count_wr)[*4];
    endsequence

    gate_high_a: assert property (
        held_s(5'h01, 1'h0) |=> count_value == $past(count_value)
    ) else $error("Count moved with high gate closed");
    gate_low_a: assert property (
        held_s(5'h02, 1'h1) |=> count_value == $past(count_value)
    ) else $error("Count moved with low gate closed");
    level_clear_a: assert property (
        held_s(5'h06, 1'h0) ##0 on_r |=> count_value == '0
    ) else $error("Count not held clear by low level");
    off_hold_a: assert property (
        !on_r && !on_wr && !count_wr |=> $stable(count_value)
    ) else $error("Count moved while disabled");
    free_step_a: assert property (
        mode == 5'h00 && on_r && $past(on_r) && !on_wr && !count_wr
        && count_value != period_value |=> count_value == $past(cnt_inc)
    ) else $error("Software gate count did not step");
    free_wrap_a: assert property (
        mode == 5'h00 && on_r && $past(on_r) && !on_wr && !count_wr
        && count_value == period_value |=> count_value == '0 && period_match_r
    ) else $error("Period match did not wrap");
    debug_keep_a: assert property (
        dbg_run_s ##0 count_value != period_value |=> count_value == $past(cnt_inc)
    ) else $error("Debug did not ignore external signal");
    shot_stop_a: assert property (
        period_match_r && mode[4:3] == hlt_pkg::FAM_ONESHOT && !$past(on_wr) |-> !on_r
    ) else $error("One-shot kept enable after match");
    mono_keep_a: assert property (
        period_match_r && mode inside {5'h11, 5'h12, 5'h13} && !$past(on_wr) |-> on_r
    ) else $error("Monostable lost enable after match");
    match_zero_a: assert property (
        period_match_r && !$past(count_wr) |-> count_value == '0
    ) else $error("Count not zero after match");
    run_flag_a: assert property (
        !$past(count_wr) && count_value != '0
        |-> count_value == (running_r ? $past(cnt_inc) : $past(count_value))
    ) else $error("Running flag disagrees with count step");
endmodule

bind hlt_timer hlt_timer_asserts #(.CNT_W(CNT_W)) chk_u (
    .core_clk(core_clk), .rst(rst), .mode(mode), .on_wr(on_wr), .on_wdata(on_wdata),
    .count_wr(count_wr), .count_wdata(count_wdata), .period_value(period_value),
    .debug_mode(debug_mode), .external_reset_signal(external_reset_signal),
    .on_r(on_r), .count_value(count_value), .running_r(running_r),
    .period_match_r(period_match_r)
);

// ==== sim/hlt_ers_src.sv ====
`timescale 1ns/100ps
// Source of the external reset signal, stepping to the asked level
module hlt_ers_src (
    input wire logic core_clk,
    input wire logic want_lvl,  // Level the bench asks for
    input wire logic slow,      // Answer five clocks later
    output logic     ers        // External reset signal
);
    logic [4:0] since_r;  // Clocks since the last change, saturating

    initial begin
        ers = 1'h0;
        since_r = 5'h1F;
    end

    // Spacing edges at least seven clocks apart also keeps each level past three
    always @(posedge core_clk) begin
        if (ers != want_lvl && since_r >= hlt_pkg::EDGE_SPACING_CYC + (slow ? 5 : 0)) begin
            ers <= want_lvl;
            since_r <= 5'h00;
        end else if (since_r != 5'h1F) begin
            since_r <= since_r + 5'h01;
        end
    end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("FAIL %0t count or enable differs", $time); end end
module tb_top;
    typedef struct packed {
        logic [7:0] mask;  // Count bits that matter
        logic [7:0] cnt;   // Expected count under the mask
        logic       on;    // Expected enable bit
    } hlt_note_t;

    logic       core_clk;
    logic       rst;
    logic [4:0] mode;
    logic       on_wr;
    logic       on_wdata;
    logic       count_wr;
    logic [7:0] count_wdata;
    logic [7:0] period_value;
    logic       debug_mode;
    logic       want_lvl;        // Level asked of the source
    logic       slow;            // Source answers late
    logic       ers;             // External reset signal
    logic       on_r;
    logic [7:0] count_value;
    logic       period_match_r;
    logic       probe;           // A note waits for the monitor
    logic [7:0] p;               // Random period or load value
    int         k;               // Clocks between matches
    int         n_errors;
    int         num_checks;
    hlt_note_t  note_q[$];       // Expected results, oldest first
    hlt_note_t  got_n;           // Note being compared
    logic [4:0] shot_m[11] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F,
                               5'h11, 5'h12, 5'h13, 5'h16};
    logic [10:0] shot_l = 11'h152;  // Idle level before the start edge
    logic [6:0] edge_l = 7'h55;    // Level driven in each edge row
    logic [6:0] edge_k = 7'h58;    // Row keeps its count (no clear)

    hlt_timer #(.CNT_W(8)) dut_u (
        .core_clk(core_clk), .rst(rst), .mode(mode), .on_wr(on_wr), .on_wdata(on_wdata),
        .count_wr(count_wr), .count_wdata(count_wdata), .period_value(period_value),
        .debug_mode(debug_mode), .external_reset_signal(ers), .on_r(on_r),
        .count_value(count_value), .running_r(), .period_match_r(period_match_r)
    );
    hlt_ers_src src_u (.core_clk(core_clk), .want_lvl(want_lvl), .slow(slow), .ers(ers));

    initial begin
        core_clk = 1'h0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic test_done();
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic set_on(input logic v);
        on_wr = 1'h1;
        on_wdata = v;
        cyc(1);
        on_wr = 1'h0;
    endtask
    task automatic load(input logic [7:0] v);
        count_wr = 1'h1;
        count_wdata = v;
        cyc(1);
        count_wr = 1'h0;
    endtask
    // Record the expectation; the monitor compares at the next edge
    task automatic note(input logic [7:0] m, input logic [7:0] c, input logic o);
        note_q.push_back('{m, c, o});
        probe = 1'h1;
        cyc(1);
        probe = 1'h0;
    endtask
    // Ask for a level, then allow for the input synchroniser
    task automatic drive(input logic l);
        int n;
        n = 0;
        want_lvl = l;
        while (ers !== l && n < 30) begin
            cyc(1);
            n++;
        end
        if (ers !== l) begin
            n_errors++;
            test_done();
        end
        cyc(6);
    endtask
    task automatic wait_match(output int c);
        c = 0;
        do begin
            cyc(1);
            c++;
        end while (period_match_r !== 1'h1 && c < 80);
        if (period_match_r !== 1'h1) begin
            n_errors++;
            test_done();
        end
    endtask

    // Monitor: oldest note against the settled outputs
    always @(posedge core_clk) begin
        if (probe === 1'h1) begin
            got_n = note_q.pop_front();
            `CHK(count_value & got_n.mask, got_n.cnt)
            `CHK(on_r, got_n.on)
        end
    end

    initial begin
        {rst, probe} = 2'h2;
        {mode, on_wr, on_wdata, count_wr, debug_mode, want_lvl, slow} = 11'h000;
        {count_wdata, period_value} = 16'h00FF;
        n_errors = 0;
        num_checks = 0;
        void'($urandom(32'h5190EC6A));
        cyc(20);
        rst = 1'h0;
        // Software gate, random period
        p = 8'($urandom_range(20, 3));
        period_value = p;
        set_on(1'h1);
        wait_match(k);
        note(8'hFF, 8'h00, 1'h1);
        wait_match(k);
        `CHK(k, int'(p))
        set_on(1'h0);
        // Software one-shot
        mode = 5'h08;
        load(8'h00);
        set_on(1'h1);
        wait_match(k);
        note(8'hFF, 8'h00, 1'h0);
        // Reserved code must not count
        mode = 5'h10;
        load(8'h05);
        set_on(1'h1);
        cyc(8);
        note(8'hFF, 8'h05, 1'h1);
        set_on(1'h0);
        // Gates and low-level clear: hold, then release
        period_value = 8'hFF;
        for (int i = 0; i < 3; i++) begin
            mode = (i == 2) ? 5'h06 : 5'(i + 1);
            drive(i == 1);
            p = {3'($urandom_range(6, 1)), 5'h00};
            load(p);
            set_on(1'h1);
            cyc(8);
            note(8'hFF, (i == 2) ? 8'h00 : p, 1'h1);
            drive(i != 1);
            note(8'hFF, ((i == 2) ? 8'h00 : p) + 8'h02, 1'h1);
            set_on(1'h0);
        end
        // Edge clears, both directions, last row in debug
        drive(1'h0);
        for (int i = 0; i < 7; i++) begin
            mode = (i == 6) ? 5'h04 : 5'(3 + i / 2);
            debug_mode = (i == 6);
            load(8'h80);
            set_on(1'h1);
            drive(edge_l[i]);
            note(8'hF0, {edge_k[i], 7'h00}, 1'h1);
            set_on(1'h0);
        end
        debug_mode = 1'h0;
        // Edge- and level-started one-shot and monostable modes
        period_value = 8'h14;
        for (int i = 0; i < 11; i++) begin
            mode = shot_m[i];
            slow = i[0];
            drive(shot_l[i]);
            load(8'h00);
            set_on(1'h1);
            cyc(8);
            note(8'hFF, 8'h00, 1'h1);
            drive(!shot_l[i]);
            wait_match(k);
            note(8'hFF, 8'h00, shot_m[i][4] & ~shot_m[i][2]);
            if (shot_m[i][4] && !shot_m[i][2]) begin
                drive(shot_l[i]);
                drive(!shot_l[i]);
                wait_match(k);
                note(8'hFF, 8'h00, 1'h1);
            end
            set_on(1'h0);
        end
        cyc(3);
        test_done();
    end
endmodule
